// ==== dump_output_map.vh ====
`ifndef DUMP_OUTPUT_MAP_VH
`define DUMP_OUTPUT_MAP_VH
// ====================================================================
// word and frame layout
`define WORD_W 32
`define FIFO_W 33
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define SPEED_BIT 32
`define FTYPE_LSB 0
`define FTYPE_MSB 2
`define FTYPE_WORD 9'h001
`define FTYPE_LTA 3'h4
`define FTYPE_SPEED 3'h3
`define LAST_IDX 9'h108
// ====================================================================
// status field positions
`define ST_FILL_LSB 0
`define ST_FILL_MSB 2
`define ST_LTA_RDY 3
`define ST_SPEED_RDY 4
// ====================================================================
// link timing in link clock edges
`define PREAMBLE_LAST 5'h0f
`define GAP_EDGES 3'h4
// ====================================================================
// synchroniser slots
`define SY_CS 0
`define SY_GRANT 1
`define SY_SUSP 2
`define SY_NRDY 3
`define SY_LCLK 4
`endif

// ==== frame_fifo.v ====
`timescale 1ns/1ps
// ====================================================================
// first-word-fall-through buffer
module frame_fifo #(
  parameter WIDTH = 33,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst_b,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count <= count + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // frame_fifo

// ==== dump_output_scheduler_port.v ====
// Notes on behaviour
// - select low enables status drivers; select high tri-states them, ignores grant.
// - status bits 0-2 report accumulation memory fullness.
// - status bit 3 set while an integrated frame is buffered.
// - status bit 4 set while a speed-dump frame is buffered.
// - grant low enables bus drivers and starts frame transmission.
// - frame-sent pulses low one link cycle after each frame.
// - grant still low four link edges after pulse starts next frame.
// - grant held with no data keeps frame-sent low until change.
// - all bus clocks derive from the link clock input.
// - once granted, honour suspend and not-ready signals and drive the direction signal low.
// - strobe runs stable sixteen link cycles before any data.
// - separate driver clock and bus strobe outputs.
// - local bus runs at the link clock period of 25 ns.
// - word 1 type field is 100 integrated, 011 speed dump.
// - final word is sum of words 0 to 264 modulo 2^32.
`timescale 1ns/1ps
`include "dump_output_map.vh"
module dump_output_scheduler_port (
  input wire clk,
  input wire rst_b,
  input wire link_clock_in,
  input wire select_n,
  input wire transmit_grant_n,
  input wire bus_suspend_n,
  input wire bus_not_ready_n,
  input wire [2:0] memory_fill,
  input wire word_valid,
  output wire word_ready,
  input wire [31:0] word_data,
  input wire word_speed,
  output reg [4:0] status_out,
  output reg status_oe,
  output reg frame_sent_n,
  output reg frame_sent_oe,
  output reg [31:0] bus_data,
  output reg bus_sync_n,
  output reg bus_valid_n,
  output reg bus_dir_n,
  output reg bus_oe,
  output reg driver_clock_out,
  output reg bus_strobe_out
);
  localparam S_IDLE = 3'h0;
  localparam S_PRE = 3'h1;
  localparam S_SEND = 3'h2;
  localparam S_CSUM = 3'h3;
  localparam S_SENT = 3'h4;
  localparam S_GAP = 3'h5;
  localparam S_HOLD = 3'h6;
  localparam S_DROP = 3'h7;

  reg [4:0] sync1;
  reg [4:0] sync2;
  reg link_prev;
  reg [2:0] state;
  reg [4:0] pre_cnt;
  reg [2:0] gap_cnt;
  reg [8:0] word_idx;
  reg [31:0] checksum;
  wire link_tick;
  wire selected;
  wire granted;
  wire paused;
  wire head_valid;
  wire head_ready;
  wire [32:0] head;
  wire [31:0] send_word;
  wire take_word;
  wire drop_word;

  // ==================================================================
  // type field insertion into word 1
  function [31:0] with_type;
    input [31:0] w;
    input [8:0] idx;
    input speed;
    begin
      with_type = w;
      if (idx == `FTYPE_WORD) begin
        with_type[`FTYPE_MSB:`FTYPE_LSB] = speed ? `FTYPE_SPEED : `FTYPE_LTA;
      end
    end
  endfunction

  // ==================================================================
  // end of frame test on the word index
  function last_word;
    input [8:0] idx;
    begin
      last_word = (idx == `LAST_IDX);
    end
  endfunction

  // ==================================================================
  // input synchronisers
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= 5'h1f;
      sync2 <= 5'h1f;
      link_prev <= 1'b1;
    end else begin
      sync1 <= {link_clock_in, bus_not_ready_n, bus_suspend_n, transmit_grant_n, select_n};
      sync2 <= sync1;
      link_prev <= sync2[`SY_LCLK];
    end
  end

  assign link_tick = sync2[`SY_LCLK] && !link_prev;
  assign selected = !sync2[`SY_CS];
  assign granted = selected && !sync2[`SY_GRANT];
  assign paused = !sync2[`SY_SUSP] || !sync2[`SY_NRDY];

  // ==================================================================
  // transmit buffer
  frame_fifo #(
    .WIDTH(`FIFO_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(word_valid),
    .in_ready(word_ready),
    .in_data({word_speed, word_data}),
    .out_valid(head_valid),
    .out_ready(head_ready),
    .out_data(head)
  );

  assign send_word = with_type(head[`WORD_W-1:0], word_idx, head[`SPEED_BIT]);
  assign take_word = (state == S_SEND) && link_tick && !paused && head_valid && granted;
  assign drop_word = (state == S_DROP) && head_valid;
  assign head_ready = take_word || drop_word;

  // ==================================================================
  // status reporting
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_out <= 5'h00;
      status_oe <= 1'b0;
    end else begin
      status_oe <= selected;
      status_out[`ST_FILL_MSB:`ST_FILL_LSB] <= memory_fill;
      status_out[`ST_LTA_RDY] <= head_valid && !head[`SPEED_BIT];
      status_out[`ST_SPEED_RDY] <= head_valid && head[`SPEED_BIT];
    end
  end

  // ==================================================================
  // transmit master sequencer
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_IDLE;
      pre_cnt <= 5'h00;
      gap_cnt <= 3'h0;
      word_idx <= 9'h000;
      checksum <= 32'h00000000;
      bus_data <= 32'h00000000;
      bus_sync_n <= 1'b1;
      bus_valid_n <= 1'b1;
      frame_sent_n <= 1'b1;
    end else begin
      case (state)
        S_IDLE: begin
          frame_sent_n <= 1'b1;
          bus_valid_n <= 1'b1;
          bus_sync_n <= 1'b1;
          if (granted) begin
            state <= S_PRE;
            pre_cnt <= 5'h00;
          end
        end
        S_PRE: begin
          if (!granted) begin
            bus_valid_n <= 1'b1;
            bus_sync_n <= 1'b1;
            state <= S_IDLE;
          end else if (link_tick) begin
            if (pre_cnt == `PREAMBLE_LAST) begin
              state <= S_SEND;
              word_idx <= 9'h000;
              checksum <= 32'h00000000;
            end else begin
              pre_cnt <= pre_cnt + 5'h01;
            end
          end
        end
        S_SEND: begin
          if (!granted) begin
            bus_valid_n <= 1'b1;
            bus_sync_n <= 1'b1;
            if (word_idx == 9'h000) begin
              state <= S_IDLE;
            end else begin
              state <= S_DROP;
            end
          end else if (link_tick) begin
            bus_valid_n <= !take_word;
            bus_sync_n <= !(take_word && word_idx == 9'h000);
            if (take_word) begin
              bus_data <= send_word;
              checksum <= checksum + send_word;
              word_idx <= word_idx + 9'h001;
              if (last_word(word_idx)) begin
                state <= S_CSUM;
              end
            end
          end
        end
        S_CSUM: begin
          if (!granted) begin
            bus_valid_n <= 1'b1;
            state <= S_IDLE;
          end else if (link_tick && !paused) begin
            bus_data <= checksum;
            bus_valid_n <= 1'b0;
            bus_sync_n <= 1'b1;
            state <= S_SENT;
          end else if (link_tick) begin
            bus_valid_n <= 1'b1;
          end
        end
        S_SENT: begin
          if (!granted) begin
            bus_valid_n <= 1'b1;
          end
          if (link_tick) begin
            bus_valid_n <= 1'b1;
            frame_sent_n <= 1'b0;
            gap_cnt <= 3'h0;
            state <= S_GAP;
          end
        end
        S_GAP: begin
          if (link_tick) begin
            frame_sent_n <= 1'b1;
            gap_cnt <= gap_cnt + 3'h1;
            if (gap_cnt + 3'h1 == `GAP_EDGES) begin
              if (!granted) begin
                state <= S_IDLE;
              end else if (head_valid) begin
                state <= S_SEND;
                word_idx <= 9'h000;
                checksum <= 32'h00000000;
              end else begin
                frame_sent_n <= 1'b0;
                state <= S_HOLD;
              end
            end
          end
        end
        S_HOLD: begin
          if (!granted) begin
            frame_sent_n <= 1'b1;
            state <= S_IDLE;
          end else if (head_valid) begin
            frame_sent_n <= 1'b1;
            state <= S_SEND;
            word_idx <= 9'h000;
            checksum <= 32'h00000000;
          end
        end
        S_DROP: begin
          bus_valid_n <= 1'b1;
          bus_sync_n <= 1'b1;
          if (drop_word) begin
            word_idx <= word_idx + 9'h001;
            if (last_word(word_idx)) begin
              state <= S_IDLE;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ==================================================================
  // bus drivers, driver clock and strobe
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_oe <= 1'b0;
      bus_dir_n <= 1'b1;
      frame_sent_oe <= 1'b0;
      driver_clock_out <= 1'b0;
      bus_strobe_out <= 1'b0;
    end else begin
      bus_oe <= (state != S_IDLE) && granted;
      bus_dir_n <= !((state != S_IDLE) && granted);
      frame_sent_oe <= selected;
      driver_clock_out <= sync2[`SY_LCLK];
      bus_strobe_out <= (state != S_IDLE) && sync2[`SY_LCLK];
    end
  end
endmodule // dump_output_scheduler_port

// ==== dump_output_checker.sv ====
`timescale 1ns/1ps
// ====
// port checker
module dump_output_checker (
  input wire clk,
  input wire rst_b,
  input wire link_clock_in,
  input wire select_n,
  input wire transmit_grant_n,
  input wire bus_suspend_n,
  input wire bus_not_ready_n,
  input wire [2:0] memory_fill,
  input wire [4:0] status_out,
  input wire status_oe,
  input wire frame_sent_oe,
  input wire bus_sync_n,
  input wire bus_valid_n,
  input wire bus_dir_n,
  input wire bus_oe,
  input wire driver_clock_out,
  input wire bus_strobe_out
);
  logic [4:0] pre_cnt;
  logic strobe_prev;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ====
  // strobe edges since the bus drivers came on
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt <= 5'h00;
      strobe_prev <= 1'b0;
    end else begin
      strobe_prev <= bus_strobe_out;
      if (!bus_oe)
        pre_cnt <= 5'h00;
      else if (bus_strobe_out && !strobe_prev && pre_cnt != 5'h1f)
        pre_cnt <= pre_cnt + 5'h01;
    end
  end
  // ====
  // assertions
  sel_on_a: assert property ((!select_n)[*4] |-> status_oe && frame_sent_oe)
    else $error("status drivers off while selected");
  sel_off_a: assert property (select_n[*4] |-> !status_oe && !frame_sent_oe && !bus_oe)
    else $error("drivers on while not selected");
  fill_a: assert property (status_oe |-> status_out[2:0] == $past(memory_fill))
    else $error("fill field wrong");
  kind_a: assert property (status_oe |-> !(status_out[3] && status_out[4]))
    else $error("both frame kinds ready");
  grant_on_a: assert property ((!select_n && !transmit_grant_n)[*5] |-> bus_oe && !bus_dir_n)
    else $error("bus not driven under grant");
  grant_off_a: assert property (transmit_grant_n[*4] |-> !bus_oe && bus_dir_n)
    else $error("bus driven without grant");
  drive_a: assert property (!bus_valid_n |-> bus_oe && !bus_dir_n)
    else $error("valid word on undriven bus");
  pause_a: assert property ($fell(bus_valid_n) |-> $past(bus_suspend_n, 3) && $past(bus_not_ready_n, 3))
    else $error("word sent while paused");
  preamble_a: assert property ($fell(bus_sync_n) |-> pre_cnt >= 5'h10)
    else $error("short strobe preamble");
  drv_clk_a: assert property ($past(rst_b, 3) && $past(rst_b, 2) && $past(rst_b) |-> driver_clock_out == $past(link_clock_in, 3))
    else $error("driver clock not from link clock");
endmodule // dump_output_checker

bind dump_output_scheduler_port dump_output_checker dump_output_checker_i (
  .clk, .rst_b, .link_clock_in, .select_n, .transmit_grant_n, .bus_suspend_n,
  .bus_not_ready_n, .memory_fill, .status_out, .status_oe, .frame_sent_oe, .bus_sync_n,
  .bus_valid_n, .bus_dir_n, .bus_oe, .driver_clock_out, .bus_strobe_out
);

// ==== sched_model.sv ====
`timescale 1ns/1ps
// ====
// scheduler stand-in
module sched_model (
  input wire clk,
  input wire want,
  input wire [1:0] pause,
  input wire status_oe,
  input wire [4:0] status_out,
  output reg select_n,
  output reg transmit_grant_n,
  output reg bus_suspend_n,
  output reg bus_not_ready_n
);
  reg [4:0] s1 = 5'h00;
  reg [4:0] s2 = 5'h00;
  initial begin
    select_n = 1'b1;
    transmit_grant_n = 1'b1;
    bus_suspend_n = 1'b1;
    bus_not_ready_n = 1'b1;
  end
  // status is read only while its drivers are on, through two stages
  always @(posedge clk) begin
    s1 <= status_oe ? status_out : 5'h00;
    s2 <= s1;
  end
  // grant only the selected device while it has a frame or is already sending
  always @(negedge clk) begin
    select_n <= !want;
    transmit_grant_n <= !(want && !select_n && (s2[4:3] != 2'b00 || !transmit_grant_n));
    bus_suspend_n <= !pause[0];
    bus_not_ready_n <= !pause[1];
  end
endmodule // sched_model

// ==== dump_output_scheduler_port_tb.sv ====
`timescale 1ns/1ps
// ====
// bench
module dump_output_scheduler_port_tb;
  logic clk = 0;
  logic rst_b = 0;
  logic link_clock_in = 0;
  logic want = 0;
  logic [1:0] pause = 2'b00;
  logic [2:0] memory_fill = 3'h0;
  logic word_valid = 0;
  logic [31:0] word_data = 32'h0;
  logic word_speed = 0;
  wire select_n, transmit_grant_n, bus_suspend_n, bus_not_ready_n, word_ready;
  wire status_oe, frame_sent_n, frame_sent_oe, bus_sync_n, bus_valid_n, bus_dir_n, bus_oe;
  wire driver_clock_out, bus_strobe_out;
  wire [4:0] status_out;
  wire [31:0] bus_data;
  int failures = 0;
  int n_tests = 0;
  int fidx = 0;
  int fnum = 0;
  int k;
  int n_frames = 4;
  int sync_pos = -1;
  logic [31:0] rx[$];
  // fill, speed flag, expected type field
  logic [6:0] rows [4] = '{7'h04, 7'h7b, 7'h54, 7'h2b};
  always #4 clk = ~clk;
  initial begin
    #37;
    forever #80 link_clock_in = ~link_clock_in;
  end
  sched_model sched_model_i (.clk, .want, .pause, .status_oe, .status_out, .select_n,
    .transmit_grant_n, .bus_suspend_n, .bus_not_ready_n);
  dump_output_scheduler_port dump_output_scheduler_port_i (.clk, .rst_b, .link_clock_in,
    .select_n, .transmit_grant_n, .bus_suspend_n, .bus_not_ready_n, .memory_fill,
    .word_valid, .word_ready, .word_data, .word_speed, .status_out, .status_oe,
    .frame_sent_n, .frame_sent_oe, .bus_data, .bus_sync_n, .bus_valid_n, .bus_dir_n,
    .bus_oe, .driver_clock_out, .bus_strobe_out);
  function automatic logic [31:0] wf(int f, int i);
    return 32'h9e3779b9 * i + f;
  endfunction
  // ====
  // upstream frame source
  always @(posedge clk) begin
    if (word_valid && word_ready) begin
      fidx <= (fidx == 264) ? 0 : fidx + 1;
      fnum <= (fidx == 264) ? fnum + 1 : fnum;
    end
  end
  always @(negedge clk) begin
    word_valid <= rst_b && fnum < n_frames;
    word_data <= wf(fnum, fidx);
    word_speed <= rows[fnum[1:0]][3];
  end
  always @(negedge bus_strobe_out) begin
    if (!bus_valid_n && !bus_sync_n) sync_pos = rx.size();
    if (!bus_valid_n) rx.push_back(bus_data);
  end
  // ====
  // reporting
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task tmo(input int n);
    if (n >= 20000) begin
      failures++;
      $display("[ERR] %0t wait expired", $time);
      finish_test;
    end
  endtask
  // ====
  // main sequence
  initial begin
    logic [31:0] sum;
    logic [31:0] w;
    repeat (5) @(negedge clk);
    rst_b = 1;
    want = 1;
    for (int r = 0; r < 4; r++) begin
      rx.delete();
      sync_pos = -1;
      memory_fill = rows[r][6:4];
      repeat (8) @(negedge clk);
      check(status_out[2:0], rows[r][6:4]);
      check(status_out[4:3], rows[r][3] ? 2'b10 : 2'b01);
      for (k = 0; k < 20000 && rx.size() < 100; k++) @(negedge clk);
      tmo(k);
      pause = r[0] ? 2'b10 : 2'b01;
      repeat (300) @(negedge clk);
      pause = 2'b00;
      for (k = 0; k < 20000 && frame_sent_n !== 1'b0; k++) @(negedge clk);
      tmo(k);
      for (k = 0; k < 60 && frame_sent_n === 1'b0; k++) @(negedge clk);
      check(k >= 19 && k <= 21, 1);
      check(rx.size(), 266);
      check(sync_pos, 0);
      sum = 0;
      for (int i = 0; i < 265; i++) begin
        w = wf(r, i);
        if (i == 1) w[2:0] = rows[r][2:0];
        check(rx[i], w);
        sum += w;
      end
      check(rx[265], sum);
    end
    repeat (200) @(negedge clk);
    check(frame_sent_n, 0);
    rx.delete();
    sync_pos = -1;
    n_frames = 5;
    for (k = 0; k < 20000 && frame_sent_n !== 1'b1; k++) @(negedge clk);
    tmo(k);
    for (k = 0; k < 20000 && frame_sent_n !== 1'b0; k++) @(negedge clk);
    tmo(k);
    check(rx.size(), 266);
    check(rx[0], wf(4, 0));
    check(sync_pos, 0);
    want = 0;
    repeat (200) @(negedge clk);
    check({bus_oe, status_oe, frame_sent_oe}, 0);
    rst_b = 0;
    @(negedge clk);
    check({frame_sent_n, bus_sync_n, bus_valid_n, bus_dir_n, bus_oe}, 5'h1e);
    finish_test;
  end
endmodule // dump_output_scheduler_port_tb
